// ---- clkmode_pkg.sv ----
// Behaviour
// - Two config bits pick fast clock source
// - Three config bits set fast RC frequency
// - Fast RC without slow crystal frees crystal pads, optional clock out
// - Any crystal mode dedicates both crystal pads
// - One config bit picks slow clock source
// - Only four fast and slow pairings allowed
// - Select bit chooses fast or slow system clock
// - Instruction clock is system clock over 2/4
// - After reset start Normal or Slow per config
// - Normal runs fast clock, slow keeps running
// - Select bit 0 to Slow, 1 back to Normal
// - Power mode field enters Standby or Halt
// - Field 10b is Standby, 01b is Halt
// - Slow keeps fast running; stop bit stops it
// - Normal timer0 may run from slow clock
// - Standby keeps timers; Halt sleeps until wake
// - Halt disables both oscillators
// - Wake resumes Normal or Slow per select bit
package clkmode_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] OSC_CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam int HCS_BIT = 0;
   localparam int STOP_BIT = 1;
   localparam int PMODE_LSB = 2;
   localparam int LCT0_BIT = 4;
   localparam logic [4:0] OSC_CTRL_RST = 5'h00;

   // ----------------------------------------
   // Configuration word fields
   // ----------------------------------------
   localparam int CFG_W = 10;
   localparam int CFG_FSRC_LSB = 0;
   localparam int CFG_RCF_LSB = 2;
   localparam int CFG_SSRC_BIT = 5;
   localparam int CFG_DIV4_BIT = 6;
   localparam int CFG_SFAST_BIT = 7;
   localparam int CFG_T0SRC_BIT = 8;
   localparam int CFG_CKOUT_BIT = 9;

   // ----------------------------------------
   // Encodings
   // ----------------------------------------
   localparam logic [1:0] FSRC_INT_RC = 2'h0;
   localparam logic [1:0] FSRC_EXT_FAST = 2'h1;
   localparam logic [1:0] FSRC_EXT_MID = 2'h2;
   localparam logic [1:0] PM_STANDBY = 2'h2;
   localparam logic [1:0] PM_HALT = 2'h1;
   localparam logic [1:0] DIV2_LAST = 2'h1;
   localparam logic [1:0] DIV4_LAST = 2'h3;

   // Operating modes, Gray along normal-slow-standby-halt
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_SLOW = 2'b01,
      MODE_STANDBY = 2'b11,
      MODE_HALT = 2'b10
   } mode_e;

endpackage : clkmode_pkg

// ---- clk_switch.sv ----
`timescale 1ns/1ps
module clk_switch
   import clkmode_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic fast_tick_i,
   input wire logic slow_tick_i,
   input wire logic sel_fast_i,
   output logic sys_tick_o,
   output logic on_fast_o
);

   logic on_fast_reg;
   logic gated_reg;
   logic sys_tick_reg;
   logic cur_tick;
   logic new_tick;

   // Ticks of the source in use and of the wanted one
   assign cur_tick = on_fast_reg ? fast_tick_i : slow_tick_i;
   assign new_tick = on_fast_reg ? slow_tick_i : fast_tick_i;

   // Close old source at its edge, open new at its edge
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         on_fast_reg <= 1'b0;
         gated_reg <= 1'b1;
      end else if (gated_reg) begin
         if (new_tick) begin
            gated_reg <= 1'b0;
            on_fast_reg <= ~on_fast_reg;
         end
      end else if (sel_fast_i != on_fast_reg && cur_tick) begin
         gated_reg <= 1'b1;
      end
   end

   // Output tick only while a source is open
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sys_tick_reg <= 1'b0;
      end else begin
         sys_tick_reg <= cur_tick & ~gated_reg;
      end
   end

   assign sys_tick_o = sys_tick_reg;
   assign on_fast_o = on_fast_reg;

   AST_NO_TICK_WHEN_GATED: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      gated_reg |=> !sys_tick_reg)
      else $error("clock output ticked during changeover");

endmodule : clk_switch

// ---- clkmode_ctrl.sv ----
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module clkmode_ctrl
   import clkmode_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Configuration word, caught after reset
   input wire logic [clkmode_pkg::CFG_W-1:0] config_word_i,
   // Oscillator ticks and wake events
   input wire logic fast_osc_tick_i,
   input wire logic slow_osc_tick_i,
   input wire logic standby_wake_i,
   input wire logic halt_wake_i,
   // Clock and mode outputs
   output logic sys_clk_tick_o,
   output logic inst_clk_tick_o,
   output logic fast_osc_en_o,
   output logic slow_osc_en_o,
   output logic [1:0] fast_src_sel_o,
   output logic [2:0] fast_rc_freq_o,
   output logic slow_src_xtal_o,
   output logic [1:0] mode_o,
   output logic cpu_run_o,
   output logic periph_run_o,
   output logic timers_run_o,
   output logic timer0_slow_clk_o,
   // Crystal pad control
   output logic xtal_pads_dedicated_o,
   output logic crystal_out_inst_clk_o,
   output logic pairing_bad_o
);
   import clkmode_pkg::*;

   // ----------------------------------------
   // Configuration capture
   // ----------------------------------------
   logic [CFG_W-1:0] cfg_reg;
   logic cfg_valid_reg;

   // Caught one edge after reset release
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_reg <= '0;
         cfg_valid_reg <= 1'b0;
      end else if (!cfg_valid_reg) begin
         cfg_reg <= config_word_i;
         cfg_valid_reg <= 1'b1;
      end
   end

   logic [1:0] fsrc;
   logic ext_fast;
   logic ext_slow;
   assign fsrc = cfg_reg[CFG_FSRC_LSB +: 2];
   assign ext_fast = (fsrc == FSRC_EXT_FAST) || (fsrc == FSRC_EXT_MID);
   assign ext_slow = cfg_reg[CFG_SSRC_BIT];

   // ----------------------------------------
   // APB register access
   // ----------------------------------------
   logic acc;
   logic wr_ctrl;
   logic [4:0] ctrl_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic sw_on_fast;
   mode_e mode_reg;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OSC_CTRL_OFS) || (a == STATUS_OFS);
   endfunction : mapped

   // Access phase, answered one cycle later
   assign acc = psel_i & penable_i & ~pready_reg;
   assign wr_ctrl = acc & pwrite_i & (paddr_i == OSC_CTRL_OFS);

   // Ready, error and read data
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= acc;
         pslverr_reg <= acc & ~mapped(paddr_i);
         if (acc && !pwrite_i) begin
            unique case (paddr_i)
               OSC_CTRL_OFS: prdata_reg <= {27'h0, ctrl_reg};
               STATUS_OFS: prdata_reg <= {24'h0, ext_slow, ext_fast,
                  pairing_bad_o, sw_on_fast, mode_reg, fast_osc_en_o,
                  slow_osc_en_o};
               default: prdata_reg <= 32'h0000_0000;
            endcase
         end else begin
            prdata_reg <= 32'h0000_0000;
         end
      end
   end

   assign pready_o = pready_reg;
   assign pslverr_o = pslverr_reg;
   assign prdata_o = prdata_reg;

   // ----------------------------------------
   // Oscillator control register
   // ----------------------------------------
   logic enter_standby;
   logic enter_halt;
   logic sys_tick;

   assign enter_standby = ctrl_reg[PMODE_LSB +: 2] == PM_STANDBY;
   assign enter_halt = ctrl_reg[PMODE_LSB +: 2] == PM_HALT;

   // Select bit starts at the startup clock choice
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_reg <= OSC_CTRL_RST;
      end else if (!cfg_valid_reg) begin
         ctrl_reg[HCS_BIT] <= config_word_i[CFG_SFAST_BIT];
      end else if (wr_ctrl) begin
         ctrl_reg <= pwdata_i[4:0];
      end else if (mode_reg == MODE_STANDBY || mode_reg == MODE_HALT) begin
         ctrl_reg[PMODE_LSB +: 2] <= 2'h0; // Request taken, field clears
      end
   end

   // ----------------------------------------
   // Operating mode machine
   // ----------------------------------------
   logic run_mode;
   assign run_mode = (mode_reg == MODE_NORMAL) || (mode_reg == MODE_SLOW);

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_reg <= MODE_SLOW;
      end else if (!cfg_valid_reg) begin
         mode_reg <= config_word_i[CFG_SFAST_BIT] ? MODE_NORMAL : MODE_SLOW;
      end else begin
         unique case (mode_reg)
            MODE_NORMAL, MODE_SLOW: begin
               if (enter_standby) begin
                  mode_reg <= MODE_STANDBY;
               end else if (enter_halt) begin
                  mode_reg <= MODE_HALT;
               end else begin
                  mode_reg <= ctrl_reg[HCS_BIT] ? MODE_NORMAL : MODE_SLOW;
               end
            end
            MODE_STANDBY: begin
               if (standby_wake_i) begin
                  mode_reg <= ctrl_reg[HCS_BIT] ? MODE_NORMAL : MODE_SLOW;
               end
            end
            MODE_HALT: begin
               if (halt_wake_i) begin
                  mode_reg <= ctrl_reg[HCS_BIT] ? MODE_NORMAL : MODE_SLOW;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Oscillator enables and run gates
   // ----------------------------------------
   logic stop_ok;
   // Stop honoured only once the switch already runs slow
   assign stop_ok = ctrl_reg[STOP_BIT] & ~sw_on_fast & ~ctrl_reg[HCS_BIT];

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fast_osc_en_o <= 1'b0;
         slow_osc_en_o <= 1'b0;
         cpu_run_o <= 1'b0;
         periph_run_o <= 1'b0;
         timers_run_o <= 1'b0;
         timer0_slow_clk_o <= 1'b0;
         mode_o <= 2'h0;
      end else begin
         fast_osc_en_o <= cfg_valid_reg & (mode_reg != MODE_HALT) & ~stop_ok;
         slow_osc_en_o <= cfg_valid_reg & (mode_reg != MODE_HALT);
         cpu_run_o <= cfg_valid_reg & run_mode;
         periph_run_o <= cfg_valid_reg & run_mode;
         timers_run_o <= cfg_valid_reg & (mode_reg != MODE_HALT);
         timer0_slow_clk_o <= (mode_reg == MODE_NORMAL) & ctrl_reg[LCT0_BIT]
            & cfg_reg[CFG_T0SRC_BIT];
         mode_o <= mode_reg;
      end
   end

   // ----------------------------------------
   // Source selection and pads
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fast_src_sel_o <= FSRC_INT_RC;
         fast_rc_freq_o <= 3'h0;
         slow_src_xtal_o <= 1'b0;
         xtal_pads_dedicated_o <= 1'b0;
         crystal_out_inst_clk_o <= 1'b0;
         pairing_bad_o <= 1'b0;
      end else begin
         fast_src_sel_o <= fsrc;
         fast_rc_freq_o <= cfg_reg[CFG_RCF_LSB +: 3];
         slow_src_xtal_o <= ext_slow;
         xtal_pads_dedicated_o <= ext_fast | ext_slow;
         crystal_out_inst_clk_o <= ~(ext_fast | ext_slow)
            & cfg_reg[CFG_CKOUT_BIT];
         pairing_bad_o <= (ext_fast & ext_slow)
            | (fsrc == 2'h3);
      end
   end

   // ----------------------------------------
   // System clock switch and divider
   // ----------------------------------------
   clk_switch u_switch (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .fast_tick_i(fast_osc_tick_i & fast_osc_en_o),
      .slow_tick_i(slow_osc_tick_i & slow_osc_en_o),
      .sel_fast_i(ctrl_reg[HCS_BIT]),
      .sys_tick_o(sys_tick),
      .on_fast_o(sw_on_fast)
   );

   logic [1:0] div_reg;
   logic [1:0] div_last;
   logic inst_tick_reg;
   logic sys_tick_reg;
   assign div_last = cfg_reg[CFG_DIV4_BIT] ? DIV4_LAST : DIV2_LAST;

   // Instruction tick every second or fourth system tick
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_reg <= 2'h0;
         inst_tick_reg <= 1'b0;
         sys_tick_reg <= 1'b0;
      end else begin
         sys_tick_reg <= sys_tick;
         inst_tick_reg <= 1'b0;
         if (sys_tick) begin
            if (div_reg >= div_last) begin
               div_reg <= 2'h0;
               inst_tick_reg <= 1'b1;
            end else begin
               div_reg <= div_reg + 2'h1;
            end
         end
      end
   end

   assign sys_clk_tick_o = sys_tick_reg;
   assign inst_clk_tick_o = inst_tick_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_halt_req;
      cfg_valid_reg && run_mode && enter_halt;
   endsequence

   sequence s_enter_halt;
      mode_reg == MODE_HALT ##1 !fast_osc_en_o && !slow_osc_en_o;
   endsequence

   AST_HALT_STOPS_OSC: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      s_halt_req |=> s_enter_halt)
      else $error("halt did not stop both oscillators");

   AST_STANDBY_ENTRY: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      cfg_valid_reg && run_mode && enter_standby
      |=> mode_reg == MODE_STANDBY ##1 timers_run_o && !cpu_run_o)
      else $error("standby entry wrong");

   AST_WAKE_RESUME: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mode_reg == MODE_HALT && halt_wake_i
      |=> mode_reg == ($past(ctrl_reg[HCS_BIT]) ? MODE_NORMAL : MODE_SLOW))
      else $error("wake resumed wrong mode");

   // Standby wake follows the select bit as well
   AST_STANDBY_WAKE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mode_reg == MODE_STANDBY && standby_wake_i
      |=> mode_reg == ($past(ctrl_reg[HCS_BIT]) ? MODE_NORMAL : MODE_SLOW))
      else $error("standby wake resumed wrong mode");

   AST_STARTUP: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      !cfg_valid_reg |=> mode_reg == (cfg_reg[CFG_SFAST_BIT] ? MODE_NORMAL : MODE_SLOW))
      else $error("startup mode wrong");

   AST_SLOW_SWITCH: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mode_reg == MODE_NORMAL && !ctrl_reg[HCS_BIT] && !enter_standby && !enter_halt
      |=> mode_reg == MODE_SLOW)
      else $error("select bit 0 did not give slow mode");

   // Select bit 1 brings the part back to normal
   AST_SELECT_RETURN: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      cfg_valid_reg && mode_reg == MODE_SLOW && ctrl_reg[HCS_BIT] && !enter_standby
      && !enter_halt |=> mode_reg == MODE_NORMAL)
      else $error("select bit 1 did not give normal mode");

   // Power mode request is consumed once the mode is entered
   AST_FIELD_CLEARS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mode_reg == MODE_STANDBY && !wr_ctrl |=> ctrl_reg[PMODE_LSB +: 2] == 2'h0)
      else $error("power mode field not cleared");

   AST_NORMAL_SLOW_RUNS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mode_reg == MODE_NORMAL && cfg_valid_reg |=> slow_osc_en_o)
      else $error("slow oscillator stopped in normal mode");

   AST_STOP_ONLY_SLOW: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      ctrl_reg[HCS_BIT] && mode_reg == MODE_NORMAL |=> fast_osc_en_o)
      else $error("fast oscillator stopped while selected");

   // Halt stops timers, cpu and peripherals alike
   AST_HALT_STOPS_TIMERS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      mode_reg == MODE_HALT |=> !timers_run_o && !cpu_run_o && !periph_run_o)
      else $error("halt left a unit running");

   AST_PADS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      xtal_pads_dedicated_o |-> !crystal_out_inst_clk_o)
      else $error("crystal pad given to clock output");

   // Any crystal source takes both pads
   AST_XTAL_PADS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      cfg_valid_reg && (ext_fast || ext_slow) |=> xtal_pads_dedicated_o)
      else $error("crystal pads left to general use");

   AST_DIV: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      inst_tick_reg && cfg_reg[CFG_DIV4_BIT] |-> !$past(inst_tick_reg))
      else $error("instruction ticks too close");

   AST_T0: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      timer0_slow_clk_o |-> $past(mode_reg) == MODE_NORMAL)
      else $error("timer0 slow clock outside normal mode");

   // Timer0 keeps its own clock unless the config bit allows slow
   AST_T0_SOURCE_OFF: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      !cfg_reg[CFG_T0SRC_BIT] |=> !timer0_slow_clk_o)
      else $error("timer0 slow clock without config bit");

endmodule : clkmode_ctrl

// ---- osc_source_model.sv ----
`timescale 1ns/1ps
module osc_source_model #(
   parameter int FAST_DIV = 3,
   parameter int SLOW_DIV = 11
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic fast_en_i,
   input wire logic slow_en_i,
   output logic fast_tick_o,
   output logic slow_tick_o
);
   int fast_cnt;
   int slow_cnt;
   // ----------------------------------------
   // Oscillator sources
   // ----------------------------------------
   // Fast source, silent while its enable is low
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fast_cnt <= 0;
         fast_tick_o <= 1'b0;
      end else begin
         fast_cnt <= (fast_cnt >= FAST_DIV - 1) ? 0 : fast_cnt + 1;
         fast_tick_o <= fast_en_i && (fast_cnt == 0);
      end
   end
   // Slow source, silent while its enable is low
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         slow_cnt <= 0;
         slow_tick_o <= 1'b0;
      end else begin
         slow_cnt <= (slow_cnt >= SLOW_DIV - 1) ? 0 : slow_cnt + 1;
         slow_tick_o <= slow_en_i && (slow_cnt == 0);
      end
   end
endmodule : osc_source_model

// ---- dual_clock_mode_controller_tb.sv ----
`timescale 1ns/1ps
module dual_clock_mode_controller_tb;
   import clkmode_pkg::*;
   logic mclk = 1'b0;
   logic rst_b, psel, penable, pwrite, sb_wake, h_wake, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [9:0] cfg;
   logic ftick, stick, sys_t, inst_t, f_en, s_en, sx, cpu, per, tmr, t0, pads, ckout, bad, e;
   logic [1:0] fsrc, mode;
   logic [2:0] rcf;
   int failures = 0;
   int check_count = 0;
   int ns, ni, nf, nl;
   // Clock
   always #20 mclk = ~mclk;
   clkmode_ctrl u_clkmode_ctrl (.mclk_i(mclk), .rst_b_i(rst_b), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .config_word_i(cfg),
      .fast_osc_tick_i(ftick), .slow_osc_tick_i(stick), .standby_wake_i(sb_wake),
      .halt_wake_i(h_wake), .sys_clk_tick_o(sys_t), .inst_clk_tick_o(inst_t),
      .fast_osc_en_o(f_en), .slow_osc_en_o(s_en), .fast_src_sel_o(fsrc),
      .fast_rc_freq_o(rcf), .slow_src_xtal_o(sx), .mode_o(mode), .cpu_run_o(cpu),
      .periph_run_o(per), .timers_run_o(tmr), .timer0_slow_clk_o(t0),
      .xtal_pads_dedicated_o(pads), .crystal_out_inst_clk_o(ckout), .pairing_bad_o(bad));
   osc_source_model u_osc_source_model (.mclk_i(mclk), .rst_b_i(rst_b), .fast_en_i(f_en),
      .slow_en_i(s_en), .fast_tick_o(ftick), .slow_tick_o(stick));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         $display("wrong value %s expected %h seen %h", n, x, g);
         failures++;
      end
   endtask : chk
   task automatic near(input string n, input int x, input int g);
      check_count++;
      if (g < x - 3 || g > x + 3) begin
         $display("wrong value %s expected %0d seen %0d", n, x, g);
         failures++;
      end
   endtask : near
   // APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Ready, read data and error taken at one rising edge
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) failures++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic do_reset(input logic [9:0] c);
      @(posedge mclk);
      cfg <= c;
      rst_b <= 1'b0;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
   endtask : do_reset
   task automatic wait_mode(input logic [1:0] m);
      int n;
      n = 0;
      @(negedge mclk);
      while (mode !== m && n < 40) begin
         @(negedge mclk);
         n++;
      end
      chk("mode", {30'h0, m}, {30'h0, mode});
   endtask : wait_mode
   task automatic count(input int c);
      ns = 0; ni = 0; nf = 0; nl = 0;
      repeat (c) begin
         @(negedge mclk);
         if (sys_t === 1'b1) ns++;
         if (inst_t === 1'b1) ni++;
         if (ftick === 1'b1) nf++;
         if (stick === 1'b1) nl++;
      end
   endtask : count
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic config_cases;
      logic [9:0] t [6];
      logic p;
      t = '{10'h041, 10'h082, 10'h0BC, 10'h0A1, 10'h083, 10'h394};
      foreach (t[k]) begin
         do_reset(t[k]);
         p = (t[k][1:0] != 2'h0) || t[k][5];
         chk("start", {31'h0, ~t[k][7]}, {30'h0, mode});
         chk("fsrc", {30'h0, t[k][1:0]}, {30'h0, fsrc});
         chk("rcf", {29'h0, t[k][4:2]}, {29'h0, rcf});
         chk("ssrc", {31'h0, t[k][5]}, {31'h0, sx});
         if (t[k][1:0] != 2'h3) chk("pads", {31'h0, p}, {31'h0, pads});
         chk("ckout", {31'h0, t[k][9] & ~p}, {31'h0, ckout});
         chk("bad", {31'h0, t[k][1:0] == 2'h3 || (t[k][1:0] != 2'h0 && t[k][5])},
            {31'h0, bad});
         count(240);
         near("inst", ns, ni * (t[k][6] ? 4 : 2));
      end
   endtask : config_cases
   task automatic slow_and_regs;
      wr(OSC_CTRL_OFS, 32'h0000_0000);
      wait_mode(2'b01);
      repeat (30) @(negedge mclk);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("status", 32'h0000_0007, q);
      count(240);
      near("slow_sys", nl, ns);
      wr(OSC_CTRL_OFS, 32'h0000_0002);
      repeat (3) @(negedge mclk);
      chk("fast_en", 32'h0, {31'h0, f_en});
      apb(1'b0, 8'h08, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      chk("unmapped_data", 32'h0, q);
      wr(8'h0C, 32'h0000_00FF);
      chk("unmapped_wr", 32'h1, {31'h0, e});
      apb(1'b0, OSC_CTRL_OFS, 32'h0);
      chk("ctrl", 32'h0000_0002, q);
      wr(OSC_CTRL_OFS, 32'h0000_0001);
      wait_mode(2'b00);
      repeat (30) @(negedge mclk);
      count(240);
      near("fast_sys", nf, ns);
      chk("slow_runs", 32'h1, {31'h0, nl > 0});
   endtask : slow_and_regs
   task automatic low_power;
      wr(OSC_CTRL_OFS, 32'h0000_0009);
      wait_mode(2'b11);
      repeat (2) @(negedge mclk);
      chk("sb_run", 32'h1, {29'h0, cpu, per, tmr});
      @(posedge mclk);
      sb_wake <= 1'b1;
      @(posedge mclk);
      sb_wake <= 1'b0;
      wait_mode(2'b00);
      wr(OSC_CTRL_OFS, 32'h0000_0000);
      wait_mode(2'b01);
      repeat (30) @(negedge mclk);
      wr(OSC_CTRL_OFS, 32'h0000_0004);
      wait_mode(2'b10);
      repeat (2) @(negedge mclk);
      chk("halt_en", 32'h0, {28'h0, f_en, s_en, tmr, per});
      @(posedge mclk);
      h_wake <= 1'b1;
      @(posedge mclk);
      h_wake <= 1'b0;
      wait_mode(2'b01);
   endtask : low_power
   task automatic timer0_case;
      wr(OSC_CTRL_OFS, 32'h0000_0011);
      wait_mode(2'b00);
      repeat (3) @(negedge mclk);
      chk("t0_normal", 32'h1, {31'h0, t0});
      wr(OSC_CTRL_OFS, 32'h0000_0010);
      wait_mode(2'b01);
      repeat (3) @(negedge mclk);
      chk("t0_slow", 32'h0, {31'h0, t0});
   endtask : timer0_case
   task automatic print_verdict;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   // Main sequence
   initial begin
      rst_b = 1'b0;
      {psel, penable, pwrite, sb_wake, h_wake} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      cfg = 10'h394;
      config_cases;
      slow_and_regs;
      low_power;
      timer0_case;
      print_verdict;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      print_verdict;
   end
endmodule : dual_clock_mode_controller_tb
